// ### adc_framer_pkg.sv
// Constants, field layouts and tag decoding for the external message framer
package adc_framer_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Command word layout, bit 31 is the first header bit
    localparam int CMD_W = 32;
    localparam int CMD_EOQ_BIT = 31;
    localparam int CMD_PAUSE_BIT = 30;
    localparam int CMD_ABORT_BIT = 27;
    localparam int CMD_EXTBUF_BIT = 26;
    localparam int CMD_BUFNUM_BIT = 25;

    ////////////////////////////////////////////////////////////////////////////
    // Serial message layout, bit 25 goes out first
    localparam int MSG_W = 26;
    localparam int MSG_CNT_W = 5;
    localparam logic [MSG_CNT_W-1:0] MSG_LAST = 5'h19;
    localparam int TAG_HI = 23;
    localparam int TAG_LO = 20;
    localparam int BUSY0_HI = 19;
    localparam int BUSY0_LO = 18;
    localparam int BUSY1_HI = 17;
    localparam int BUSY1_LO = 16;
    localparam int RESULT_HI = 15;
    localparam int RESULT_W = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Tag and busy codes
    localparam logic [3:0] TAG_LAST_RESULT = 4'h5;
    localparam logic [3:0] TAG_NULL = 4'h8;
    localparam logic [3:0] TAG_CUST_A = 4'h9;
    localparam logic [3:0] TAG_CUST_B = 4'hA;
    localparam logic [1:0] BUSY_STOP = 2'h3;
    localparam logic [2:0] TOP_FIFO = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_NULL_FORMAT = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_RESULT = 4'hC;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [MSG_W-1:0] NULL_FORMAT_RESET = 26'h000_0000;
    localparam logic [1:0] BUF_FULL_RESET = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Tag decoding
    function automatic logic tag_is_result(input logic [3:0] tag);
        return tag <= TAG_LAST_RESULT;
    endfunction

    function automatic logic tag_is_null(input logic [3:0] tag);
        return (tag == TAG_NULL) || (tag == TAG_CUST_A) || (tag == TAG_CUST_B);
    endfunction

endpackage

// ### message_shifter.sv
// Serial shifter for one 26-bit outgoing and one 26-bit incoming message
`timescale 1ns/1ps
module message_shifter
    import adc_framer_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Control
    input wire logic i_start,
    input wire logic [MSG_W-1:0] i_tx_word,
    input wire logic i_abort,
    output logic o_busy,
    output logic o_active,
    output logic o_done,
    // Received message
    output logic o_rx_valid,
    output logic [MSG_W-1:0] o_rx_word,
    // Link pins
    output logic o_sdo,
    output logic o_frame,
    input wire logic i_sdi
);

    logic [MSG_W-1:0] tx_shift;
    logic [MSG_CNT_W-1:0] tx_count;
    logic [MSG_CNT_W-1:0] rx_count;
    logic [1:0] frame_pipe;
    logic sdi_meta;
    logic sdi_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Busy until the delayed receive window has closed
    assign o_busy = o_frame | (|frame_pipe);
    assign o_active = o_frame;
    assign o_sdo = tx_shift[MSG_W-1];

    // Two-stage input synchroniser
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            sdi_meta <= 1'b0;
            sdi_sync <= 1'b0;
        end
        else if (i_clk_en)
        begin
            sdi_meta <= i_sdi;
            sdi_sync <= sdi_meta;
        end
    end

    // Transmit side, header never reaches this shifter
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            tx_shift <= '0;
            tx_count <= '0;
            o_frame <= 1'b0;
            o_done <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_done <= 1'b0;
            if (i_abort)
            begin
                o_frame <= 1'b0;
                tx_count <= '0;
            end
            else if (i_start && !o_busy)
            begin
                tx_shift <= i_tx_word; // see [RQ7]
                tx_count <= '0;
                o_frame <= 1'b1;
            end
            else if (o_frame)
            begin
                tx_shift <= {tx_shift[MSG_W-2:0], 1'b0};
                tx_count <= tx_count + 5'h01;
                if (tx_count == MSG_LAST)
                begin
                    o_frame <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end

    // Receive side, window delayed to match the synchroniser
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            frame_pipe <= '0;
            rx_count <= '0;
            o_rx_word <= '0;
            o_rx_valid <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_rx_valid <= 1'b0;
            if (i_abort)
            begin
                frame_pipe <= '0;
                rx_count <= '0;
            end
            else
            begin
                frame_pipe <= {frame_pipe[0], o_frame};
                if (frame_pipe[1])
                begin
                    o_rx_word <= {o_rx_word[MSG_W-2:0], sdi_sync};
                    rx_count <= (rx_count == MSG_LAST) ? 5'h00 : rx_count + 5'h01;
                    o_rx_valid <= (rx_count == MSG_LAST); // see [RQ8]
                end
            end
        end
    end

endmodule

// ### adc_external_message_framer.sv
// Command, result and null message framer for an external converter link
// Functional notes
// [RQ1] End of queue clears the transfer counter
// [RQ2] Pause enters wait-for-trigger in edge modes
// [RQ3] Pause with end of queue acts as end
// [RQ4] Abort: nulls by any, commands by top FIFO
// [RQ5] External commands carry the buffer select set
// [RQ6] Buffer number picks external buffer zero or one
// [RQ7] Only buffer number and command are shifted
// [RQ8] Decode tag, two busy fields and result
// [RQ9] Result tags push only the 16-bit result
// [RQ10] Null tag never reaches a result FIFO
// [RQ11] Busy code three forbids sending, others allow
// [RQ12] Device reports do-not-send when buffer full
// [RQ13] Intermediate busy codes both mean send
// [RQ14] Both buffers treated full after reset
// [RQ15] Null sent when enabled and nothing sendable
// [RQ16] Null message is the programmed pattern
// [RQ17] Null replies carry null tag and busy
// [RQ18] Tags zero to five route to FIFOs
// [RQ19] Customer tags handled as null messages
// [RQ20] Reserved bits ignored for routing and busy
`timescale 1ns/1ps
module adc_external_message_framer
    import adc_framer_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Avalon-MM register slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Command offered by the winning triggered FIFO
    input wire logic i_cmd_valid,
    input wire logic [CMD_W-1:0] i_cmd_word,
    input wire logic [2:0] i_cmd_fifo,
    input wire logic i_cmd_edge_mode,
    output logic o_cmd_ready,
    // Transfer completion towards the FIFO control
    output logic o_xfer_done,
    output logic o_xfer_aborted,
    output logic [2:0] o_xfer_fifo,
    output logic o_end_of_queue_flag,
    output logic o_pause_flag,
    output logic o_clear_transfer_counter,
    output logic o_enter_wait_trigger,
    // Result towards the result FIFOs
    output logic o_result_valid,
    output logic [2:0] o_result_fifo,
    output logic [RESULT_W-1:0] o_result_data,
    // Serial link
    output logic o_link_sdo,
    output logic o_link_frame,
    input wire logic i_link_sdi
);

    logic serial_enable_field;
    logic [MSG_W-1:0] null_send_format_reg;
    logic [1:0] buffer_full;
    logic [1:0] busy0_raw;
    logic [1:0] busy1_raw;
    logic [3:0] last_tag;
    logic bus_ack;
    logic cur_is_null;
    logic [2:0] cur_fifo;
    logic cur_eoq;
    logic cur_pause;
    logic cur_edge;
    logic shift_busy;
    logic shift_active;
    logic shift_done;
    logic rx_valid;
    logic [MSG_W-1:0] rx_word;
    logic [3:0] rx_tag;
    logic [1:0] rx_busy0;
    logic [1:0] rx_busy1;
    logic cmd_eligible;
    logic abort_now;
    logic start_null;
    logic start_cmd;
    logic [MSG_W-1:0] tx_word;

    // Merge write data under byte enables
    function automatic logic [31:0] apply_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then the access completes
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_ack;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            bus_ack <= 1'b0;
        end
        else if (i_clk_en)
        begin
            bus_ack <= (i_avs_read | i_avs_write) & ~bus_ack;
        end
    end

    // Read data prepared in the wait cycle
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_avs_readdata <= '0;
        end
        else if (i_clk_en && i_avs_read && !bus_ack)
        begin
            unique case (i_avs_address)
                REG_CONTROL: o_avs_readdata <= {31'h0, serial_enable_field};
                REG_NULL_FORMAT: o_avs_readdata <= {6'h00, null_send_format_reg};
                REG_STATUS: o_avs_readdata <= {20'h00000, busy1_raw, busy0_raw, last_tag,
                                               cur_is_null, shift_busy, buffer_full};
                REG_RESULT: o_avs_readdata <= {16'h0000, o_result_data};
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Writable registers, taken at the completing edge
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            serial_enable_field <= CONTROL_RESET[CTRL_ENABLE_BIT];
            null_send_format_reg <= NULL_FORMAT_RESET;
        end
        else if (i_clk_en && i_avs_write && bus_ack)
        begin
            if (i_avs_address == REG_CONTROL)
            begin
                serial_enable_field <= i_avs_byteenable[CTRL_ENABLE_BIT / 8]
                    ? i_avs_writedata[CTRL_ENABLE_BIT] : serial_enable_field;
            end
            if (i_avs_address == REG_NULL_FORMAT)
            begin
                null_send_format_reg <= MSG_W'(apply_be({6'h00, null_send_format_reg},
                    i_avs_writedata, i_avs_byteenable));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command acceptance and abort decisions
    assign cmd_eligible = serial_enable_field && i_cmd_valid
        && i_cmd_word[CMD_EXTBUF_BIT] // see [RQ5]
        && !buffer_full[i_cmd_word[CMD_BUFNUM_BIT]]; // see [RQ6] [RQ11]
    assign abort_now = cmd_eligible && i_cmd_word[CMD_ABORT_BIT] && shift_active
        && (cur_is_null || ((i_cmd_fifo == TOP_FIFO) && (cur_fifo != TOP_FIFO))); // see [RQ4]
    assign start_cmd = cmd_eligible && !shift_busy;
    assign start_null = serial_enable_field && !shift_busy && !cmd_eligible; // see [RQ15]
    assign o_cmd_ready = start_cmd;
    assign tx_word = start_cmd ? i_cmd_word[MSG_W-1:0] : null_send_format_reg; // see [RQ7] [RQ16]

    // Context of the frame in flight
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            cur_is_null <= 1'b0;
            cur_fifo <= '0;
            cur_eoq <= 1'b0;
            cur_pause <= 1'b0;
            cur_edge <= 1'b0;
        end
        else if (i_clk_en && (start_cmd || start_null))
        begin
            cur_is_null <= start_null;
            cur_fifo <= i_cmd_fifo;
            cur_eoq <= start_cmd & i_cmd_word[CMD_EOQ_BIT];
            cur_pause <= start_cmd & i_cmd_word[CMD_PAUSE_BIT];
            cur_edge <= i_cmd_edge_mode;
        end
    end

    // Completion and abort pulses
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_xfer_done <= 1'b0;
            o_xfer_aborted <= 1'b0;
            o_xfer_fifo <= '0;
            o_end_of_queue_flag <= 1'b0;
            o_pause_flag <= 1'b0;
            o_clear_transfer_counter <= 1'b0;
            o_enter_wait_trigger <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_xfer_done <= shift_done && !cur_is_null;
            o_xfer_aborted <= abort_now && !cur_is_null;
            o_xfer_fifo <= cur_fifo;
            o_end_of_queue_flag <= shift_done && !cur_is_null && cur_eoq;
            o_pause_flag <= shift_done && !cur_is_null && cur_pause; // see [RQ3]
            o_clear_transfer_counter <= shift_done && !cur_is_null && cur_eoq; // see [RQ1]
            o_enter_wait_trigger <= shift_done && !cur_is_null && cur_pause
                && cur_edge && !cur_eoq; // see [RQ2] [RQ3]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial shifter
    message_shifter u_shifter (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_start(start_cmd | start_null),
        .i_tx_word(tx_word),
        .i_abort(abort_now),
        .o_busy(shift_busy),
        .o_active(shift_active),
        .o_done(shift_done),
        .o_rx_valid(rx_valid),
        .o_rx_word(rx_word),
        .o_sdo(o_link_sdo),
        .o_frame(o_link_frame),
        .i_sdi(i_link_sdi)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Returning message fields, top two bits unused
    assign rx_tag = rx_word[TAG_HI:TAG_LO]; // see [RQ8] [RQ20]
    assign rx_busy0 = rx_word[BUSY0_HI:BUSY0_LO];
    assign rx_busy1 = rx_word[BUSY1_HI:BUSY1_LO];

    // Buffer availability, only well-tagged messages count
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            buffer_full <= BUF_FULL_RESET; // see [RQ14]
            busy0_raw <= BUSY_STOP;
            busy1_raw <= BUSY_STOP;
            last_tag <= TAG_NULL;
        end
        else if (i_clk_en && rx_valid)
        begin
            last_tag <= rx_tag;
            if (tag_is_result(rx_tag) || tag_is_null(rx_tag)) // see [RQ19] [RQ20]
            begin
                buffer_full[0] <= (rx_busy0 == BUSY_STOP); // see [RQ11] [RQ13]
                buffer_full[1] <= (rx_busy1 == BUSY_STOP);
                busy0_raw <= rx_busy0;
                busy1_raw <= rx_busy1;
            end
        end
    end

    // Result routing to result FIFOs
    always_ff @(posedge i_sys_clk)
    begin
        if (i_rst)
        begin
            o_result_valid <= 1'b0;
            o_result_fifo <= '0;
            o_result_data <= '0;
        end
        else if (i_clk_en)
        begin
            o_result_valid <= rx_valid && tag_is_result(rx_tag); // see [RQ9] [RQ10] [RQ18]
            if (rx_valid && tag_is_result(rx_tag))
            begin
                o_result_fifo <= rx_tag[2:0]; // see [RQ18]
                o_result_data <= rx_word[RESULT_HI:0]; // see [RQ9]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_done_cmd;
        i_clk_en && shift_done && !cur_is_null;
    endsequence

    property p_eoq_clear;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_done_cmd and (cur_eoq) |=> o_clear_transfer_counter && o_end_of_queue_flag;
    endproperty
    a_eoq_clear: assert property (p_eoq_clear) else $error("end of queue not cleared"); // see [RQ1]

    property p_pause_wait;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_done_cmd and (cur_pause && cur_edge && !cur_eoq) |=> o_enter_wait_trigger;
    endproperty
    a_pause_wait: assert property (p_pause_wait) else $error("pause missed wait"); // see [RQ2]

    property p_both_flags;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_done_cmd and (cur_pause && cur_eoq) |=> o_pause_flag && !o_enter_wait_trigger;
    endproperty
    a_both_flags: assert property (p_both_flags) else $error("pause with end mishandled"); // see [RQ3]

    property p_abort_rights;
        @(posedge i_sys_clk) disable iff (i_rst)
        abort_now && !cur_is_null |-> i_cmd_fifo == TOP_FIFO && cur_fifo != TOP_FIFO;
    endproperty
    a_abort_rights: assert property (p_abort_rights) else $error("illegal abort"); // see [RQ4]

    property p_ready_allowed;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_cmd_ready |-> i_cmd_word[CMD_EXTBUF_BIT] && !buffer_full[i_cmd_word[CMD_BUFNUM_BIT]];
    endproperty
    a_ready_allowed: assert property (p_ready_allowed) else $error("sent to full buffer"); // see [RQ11]

    sequence s_frame_open;
        i_clk_en && (start_cmd || start_null);
    endsequence

    property p_frame_len;
        @(posedge i_sys_clk) disable iff (i_rst || !i_clk_en || abort_now)
        s_frame_open |=> o_link_frame [*8];
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame too short"); // see [RQ7]

    property p_result_push;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_clk_en && rx_valid && tag_is_result(rx_tag) |=>
            o_result_valid && o_result_data == $past(rx_word[RESULT_HI:0]);
    endproperty
    a_result_push: assert property (p_result_push) else $error("result not pushed"); // see [RQ9]

    property p_null_dropped;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_clk_en && rx_valid && !tag_is_result(rx_tag) |=> !o_result_valid;
    endproperty
    a_null_dropped: assert property (p_null_dropped) else $error("null tag pushed"); // see [RQ10]

    property p_busy_update;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_clk_en && rx_valid && tag_is_null(rx_tag) |=>
            buffer_full[1] == ($past(rx_busy1) == BUSY_STOP);
    endproperty
    a_busy_update: assert property (p_busy_update) else $error("busy not decoded"); // see [RQ19]

    property p_reset_full;
        @(posedge i_sys_clk) $past(i_rst) |-> buffer_full == BUF_FULL_RESET;
    endproperty
    a_reset_full: assert property (p_reset_full) else $error("buffers not full at reset"); // see [RQ14]

    property p_null_when_idle;
        @(posedge i_sys_clk) disable iff (i_rst)
        start_null |-> serial_enable_field && tx_word == null_send_format_reg;
    endproperty
    a_null_when_idle: assert property (p_null_when_idle) else $error("bad null send"); // see [RQ16]

endmodule

// ### ext_converter_model.sv
// Behavioural external converter on the serial link
`timescale 1ns/1ps
module ext_converter_model
(
    // Link from the framer
    input wire logic i_sys_clk,
    input wire logic i_frame,
    input wire logic i_sdo,
    // Reply word set by the bench
    input wire logic [25:0] i_reply,
    // Link back and captured frame
    output logic o_sdi,
    output logic [25:0] o_seen,
    output logic o_seen_valid
);
    logic [4:0] cnt = 5'h00;
    logic last = 1'b0;
    logic [25:0] sh = 26'h000_0000;
    ////////////////////////////////////////////////////////////
    // Reply bit per frame cycle, inverse of last bit when idle
    assign o_sdi = i_frame ? i_reply[5'h19 - cnt] : ~last;
    // Capture outgoing bits, publish word at frame end
    always @(posedge i_sys_clk)
    begin
        o_seen_valid <= 1'b0;
        if (i_frame)
        begin
            cnt <= cnt + 5'h01;
            last <= o_sdi;
            sh <= {sh[24:0], i_sdo};
        end
        else if (cnt != 5'h00)
        begin
            cnt <= 5'h00;
            o_seen <= sh;
            o_seen_valid <= 1'b1;
        end
    end
endmodule

// ### test_adc_external_message_framer.sv
// Self-checking bench for the external message framer
`timescale 1ns/1ps
module test_adc_external_message_framer;
    import adc_framer_pkg::*;
    localparam logic [25:0] NULLW = 26'h2AB_CDEF;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic cmd_valid = 1'b0;
    logic [31:0] cmd_word = 32'h0;
    logic [2:0] cmd_fifo = 3'h0;
    logic edge_mode = 1'b0;
    logic [25:0] reply = 26'h0;
    logic [31:0] rdata, rd;
    logic wreq, ready, done, end_of_queue_flag, pause, clr, wt, res_v, sdo, frame, sdi, seen_v;
    logic [2:0] xfifo, result_queue_fifo, ab;
    logic abt;
    int n_abt = 0;
    logic [15:0] rres;
    logic [25:0] seen, w;
    logic [6:0] flags;
    logic [18:0] res;
    int bad_count = 0;
    int cmp_count = 0;
    int n_take = 0;
    int n_res = 0;
    ////////////////////////////////////////////////////////////
    // Clock
    always #4 i_sys_clk = ~i_sys_clk;
    // Design and far side
    adc_external_message_framer dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1),
        .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_cmd_valid(cmd_valid), .i_cmd_word(cmd_word),
        .i_cmd_fifo(cmd_fifo), .i_cmd_edge_mode(edge_mode), .o_cmd_ready(ready),
        .o_xfer_done(done), .o_xfer_aborted(abt), .o_xfer_fifo(xfifo),
        .o_end_of_queue_flag(end_of_queue_flag), .o_pause_flag(pause), .o_clear_transfer_counter(clr),
        .o_enter_wait_trigger(wt), .o_result_valid(res_v), .o_result_fifo(result_queue_fifo),
        .o_result_data(rres), .o_link_sdo(sdo), .o_link_frame(frame), .i_link_sdi(sdi));
    ext_converter_model conv_u (.i_sys_clk(i_sys_clk), .i_frame(frame), .i_sdo(sdo),
        .i_reply(reply), .o_sdi(sdi), .o_seen(seen), .o_seen_valid(seen_v));
    // Monitor of takes, completions and results
    always @(negedge i_sys_clk)
    begin
        if (done === 1'b1)
            flags <= {xfifo, end_of_queue_flag, pause, clr, wt};
        if (res_v === 1'b1)
        begin
            n_res++;
            res <= {result_queue_fifo, rres};
        end
        if (abt === 1'b1)
        begin
            n_abt++;
            ab <= xfifo;
        end
        if (ready === 1'b1)
        begin
            n_take++;
            @(posedge i_sys_clk);
            cmd_valid <= 1'b0;
        end
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        bad_count++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, s);
        end
    endtask
    // One Avalon access, held until waitrequest is low
    task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        addr <= a;
        wdata <= d;
        wr_en <= is_wr;
        rd_en <= ~is_wr;
        do
            @(posedge i_sys_clk);
        while (wreq !== 1'b0);
        rd = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask
    function automatic logic [25:0] msg(input logic [3:0] t, input logic [1:0] b0, b1,
        input logic [15:0] r);
        return {2'b11, t, b0, b1, r};
    endfunction
    // Enable the link until a frame is seen, return what was sent
    task automatic frame_with(input logic [25:0] rep);
        int n;
        @(posedge i_sys_clk);
        reply <= rep;
        bus(1'b1, REG_CONTROL, 32'h1);
        for (n = 0; n < 100 && seen_v !== 1'b1; n++)
            @(negedge i_sys_clk);
        check("frame seen", n < 100, 1);
        w = seen;
        bus(1'b1, REG_CONTROL, 32'h0);
        repeat (60) @(posedge i_sys_clk);
    endtask
    task automatic t_reset();
        bus(1'b0, REG_CONTROL, 32'h0);
        check("control", rd, 32'h0);
        bus(1'b0, REG_NULL_FORMAT, 32'h0);
        check("null format", rd, 32'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        check("full", rd[1:0], 32'h3);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", rd, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_busy();
        logic [3:0] tg [4] = '{4'h8, 4'h9, 4'hA, 4'h8};
        bus(1'b1, REG_NULL_FORMAT, {6'h0, NULLW});
        @(posedge i_sys_clk);
        cmd_word <= 32'h0400_1234;
        cmd_valid <= 1'b1;
        frame_with(msg(4'h8, 2'h3, 2'h3, 16'h0));
        check("null frame", w, NULLW);
        check("takes", n_take, 0);
        @(posedge i_sys_clk);
        cmd_valid <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            frame_with(msg(tg[i], i[1:0], 2'h3 - i[1:0], 16'hBEEF));
            bus(1'b0, REG_STATUS, 32'h0);
            check("busy", rd[1:0], {i == 0, i == 3});
        end
        frame_with(msg(4'h6, 2'h0, 2'h3, 16'h1111));
        bus(1'b0, REG_STATUS, 32'h0);
        check("reserved tag", rd[1:0], 32'h1);
        check("results", n_res, 0);
        $display("busy test done");
    endtask
    task automatic t_cmd();
        @(posedge i_sys_clk);
        cmd_word <= 32'hF600_5A5A;
        cmd_fifo <= 3'h2;
        edge_mode <= 1'b1;
        cmd_valid <= 1'b1;
        frame_with(msg(4'h8, 2'h1, 2'h2, 16'h0));
        check("cmd frame", w, 26'h200_5A5A);
        check("flags", flags, {3'h2, 4'b1110});
        @(posedge i_sys_clk);
        cmd_word <= 32'h4500_00C3;
        cmd_fifo <= 3'h4;
        cmd_valid <= 1'b1;
        frame_with(msg(4'h8, 2'h0, 2'h3, 16'h0));
        check("cmd frame", w, 26'h100_00C3);
        check("flags", flags, {3'h4, 4'b0101});
        @(posedge i_sys_clk);
        cmd_word <= 32'h0000_0001;
        cmd_valid <= 1'b1;
        frame_with(msg(4'h5, 2'h0, 2'h0, 16'hA5C3));
        check("no eb frame", w, NULLW);
        check("takes", n_take, 2);
        check("result", res, {3'h5, 16'hA5C3});
        check("pushed", n_res > 0, 1);
        $display("command test done");
    endtask
    // Null cut by a low FIFO, then its command cut by the top FIFO
    task automatic t_abort();
        bus(1'b1, REG_CONTROL, 32'h1);
        repeat (5) @(posedge i_sys_clk);
        cmd_word <= 32'h0C00_0077;
        cmd_fifo <= 3'h3;
        cmd_valid <= 1'b1;
        repeat (10) @(posedge i_sys_clk);
        cmd_word <= 32'h0C00_0011;
        cmd_fifo <= 3'h0;
        cmd_valid <= 1'b1;
        repeat (10) @(posedge i_sys_clk);
        bus(1'b1, REG_CONTROL, 32'h0);
        repeat (60) @(posedge i_sys_clk);
        check("takes", n_take, 4);
        check("aborts", n_abt, 1);
        check("aborted fifo", ab, 3'h3);
        $display("abort test done");
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (3) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_reset();
        t_busy();
        t_cmd();
        t_abort();
        end_sim();
    end
endmodule
